/* hdl/irqpl_device.sv */
// interrupt unit end: request pins, cascade, slave and nmi handling
`timescale 1ns/1ps
`include "irqpl_defines.svh"
module irqpl_device #(
    parameter int NUM_REQ = `IRQPL_NUM_REQ,
    parameter int TYPE_W = `IRQPL_TYPE_W
) (
    input wire logic i_core_clk,
    input wire logic i_srst,
    irqpl_if.device pins,
    input wire logic [NUM_REQ-1:0] i_mask,
    input wire logic [NUM_REQ-1:0] i_trigger_level,
    input wire logic i_cascade_0,
    input wire logic i_cascade_1,
    input wire logic i_slave_mode,
    input wire logic i_internal_req,
    input wire logic i_enable_set,
    input wire logic i_boundary,
    output logic o_cpu_request,
    output logic o_vector_valid,
    output logic [TYPE_W-1:0] o_vector,
    output logic o_vector_is_nmi,
    output logic o_global_enable
);

    // ****************************************
    // input synchronisers
    // ****************************************
    logic [`IRQPL_NUM_SYNC-1:0] raw;
    logic [`IRQPL_NUM_SYNC-1:0] sync_1;
    logic [`IRQPL_NUM_SYNC-1:0] sync_2;
    logic [`IRQPL_NUM_SYNC-1:0] sync_prev;

    always_comb begin
        raw = '0;
        raw[0] = pins.maskable_request_0;
        raw[1] = i_slave_mode ? 1'b0 : pins.maskable_request_1;
        raw[2] = i_cascade_0 ? 1'b0 : pins.maskable_request_2;
        raw[3] = (i_cascade_1 || i_slave_mode) ? 1'b0 : pins.maskable_request_3;
        raw[4] = pins.maskable_request_4;
        raw[`IRQPL_SYNC_NMI] = pins.nmi;
        raw[`IRQPL_SYNC_SEL] = i_slave_mode ? ~pins.maskable_request_1 : 1'b0;
    end

    always_ff @(posedge i_core_clk) begin
        if (i_srst) begin
            sync_1 <= '0;
            sync_2 <= '0;
            sync_prev <= '0;
        end else begin
            sync_1 <= raw;
            sync_2 <= sync_1;
            sync_prev <= sync_2;
        end
    end

    logic [`IRQPL_NUM_SYNC-1:0] rise;
    assign rise = sync_2 & ~sync_prev;

    // ****************************************
    // pending, nmi latch, slave type, sequencer
    // ****************************************
    irqpl_pkg::irqpl_dev_state_type state, next_state;
    logic [NUM_REQ-1:0] pend, next_pend;
    logic nmi_latched, next_nmi_latched;
    logic slave_ready, next_slave_ready;
    logic [TYPE_W-1:0] slave_type, next_slave_type;
    logic global_enable, next_global_enable;
    logic [`IRQPL_IDX_W-1:0] fetch_src, next_fetch_src;
    logic [2:0] count, next_count;
    logic ack_0, next_ack_0;
    logic ack_1, next_ack_1;
    logic vec_valid, next_vec_valid;
    logic [TYPE_W-1:0] vec, next_vec;
    logic vec_nmi, next_vec_nmi;
    logic [NUM_REQ-1:0] active;
    logic any_active;
    logic [`IRQPL_IDX_W-1:0] win;
    logic [NUM_REQ-1:0] serve;

    assign active = pend & ~i_mask;
    assign any_active = |active;

    always_comb begin
        win = '0;
        for (int i = NUM_REQ - 1; i >= 0; i--) begin
            if (active[i]) begin
                win = i[`IRQPL_IDX_W-1:0];
            end
        end
    end

    always_comb begin
        next_state = state;
        next_nmi_latched = nmi_latched;
        next_slave_ready = slave_ready;
        next_slave_type = slave_type;
        next_global_enable = global_enable || i_enable_set;
        next_fetch_src = fetch_src;
        next_count = count;
        next_ack_0 = 1'b0;
        next_ack_1 = 1'b0;
        next_vec_valid = 1'b0;
        next_vec = vec;
        next_vec_nmi = vec_nmi;
        serve = '0;
        // slave: select edge with request zero pending latches bus type
        if (i_slave_mode && rise[`IRQPL_SYNC_SEL] && pend[0] && pins.type_bus_oe) begin
            next_slave_ready = 1'b1;
            next_slave_type = pins.type_bus;
        end
        unique case (state)
            irqpl_pkg::DEV_IDLE: begin
                if (i_boundary && nmi_latched) begin
                    next_nmi_latched = 1'b0;
                    next_vec_valid = 1'b1;
                    next_vec = `IRQPL_VEC_NMI;
                    next_vec_nmi = 1'b1;
                    next_global_enable = 1'b0;
                end else if (i_boundary && global_enable && i_slave_mode) begin
                    if (slave_ready) begin
                        next_slave_ready = 1'b0;
                        serve[0] = 1'b1;
                        next_vec_valid = 1'b1;
                        next_vec = slave_type;
                        next_vec_nmi = 1'b0;
                        next_global_enable = 1'b0;
                    end
                end else if (i_boundary && global_enable && any_active) begin
                    next_global_enable = 1'b0;
                    if ((win == `IRQPL_SRC_0 && i_cascade_0) ||
                        (win == `IRQPL_SRC_1 && i_cascade_1)) begin
                        next_state = irqpl_pkg::DEV_FETCH;
                        next_fetch_src = win;
                        next_count = `IRQPL_ACK_CYCLES;
                        next_ack_0 = (win == `IRQPL_SRC_0);
                        next_ack_1 = (win == `IRQPL_SRC_1);
                    end else begin
                        serve[win] = 1'b1;
                        next_vec_valid = 1'b1;
                        next_vec = `IRQPL_VEC_BASE + TYPE_W'(win);
                        next_vec_nmi = 1'b0;
                    end
                end
            end
            irqpl_pkg::DEV_FETCH: begin
                if (count == `IRQPL_CNT_ONE) begin
                    next_state = irqpl_pkg::DEV_IDLE;
                    serve[fetch_src] = 1'b1;
                    next_vec_valid = 1'b1;
                    next_vec = pins.type_bus;
                    next_vec_nmi = 1'b0;
                    next_count = `IRQPL_CNT_ZERO;
                end else begin
                    next_count = count - `IRQPL_CNT_ONE;
                    next_ack_0 = (fetch_src == `IRQPL_SRC_0);
                    next_ack_1 = (fetch_src == `IRQPL_SRC_1);
                end
            end
        endcase
        // nmi edge latched; a new edge wins over the clear
        if (rise[`IRQPL_SYNC_NMI]) begin
            next_nmi_latched = 1'b1;
        end
    end

    always_comb begin
        for (int i = 0; i < NUM_REQ; i++) begin
            if (i_trigger_level[i]) begin
                next_pend[i] = sync_2[i];
            end else begin
                next_pend[i] = rise[i] || (pend[i] && !serve[i]);
            end
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (i_srst) begin
            state <= irqpl_pkg::DEV_IDLE;
            pend <= '0;
            nmi_latched <= 1'b0;
            slave_ready <= 1'b0;
            slave_type <= '0;
            global_enable <= 1'b0;
            fetch_src <= '0;
            count <= `IRQPL_CNT_ZERO;
            ack_0 <= 1'b0;
            ack_1 <= 1'b0;
            vec_valid <= 1'b0;
            vec <= '0;
            vec_nmi <= 1'b0;
        end else begin
            state <= next_state;
            pend <= next_pend;
            nmi_latched <= next_nmi_latched;
            slave_ready <= next_slave_ready;
            slave_type <= next_slave_type;
            global_enable <= next_global_enable;
            fetch_src <= next_fetch_src;
            count <= next_count;
            ack_0 <= next_ack_0;
            ack_1 <= next_ack_1;
            vec_valid <= next_vec_valid;
            vec <= next_vec;
            vec_nmi <= next_vec_nmi;
        end
    end

    // ****************************************
    // pin and processor outputs
    // ****************************************
    assign pins.cascade_ack_out_0_n = ~ack_0;
    assign pins.cascade_ack_0_oe = i_cascade_0;
    assign pins.pin3_out = i_slave_mode ? i_internal_req : ~ack_1;
    assign pins.pin3_oe = i_cascade_1 || i_slave_mode;

    assign o_cpu_request = (state == irqpl_pkg::DEV_IDLE) && (nmi_latched ||
        (global_enable && (i_slave_mode ? slave_ready : any_active)));
    assign o_vector_valid = vec_valid;
    assign o_vector = vec;
    assign o_vector_is_nmi = vec_nmi;
    assign o_global_enable = global_enable;

endmodule : irqpl_device

/* hdl/irqpl_defines.svh */
// constants of the interrupt request pin logic
`ifndef IRQPL_DEFINES_SVH
`define IRQPL_DEFINES_SVH

`define IRQPL_NUM_REQ 5
`define IRQPL_TYPE_W 8
`define IRQPL_IDX_W 3
`define IRQPL_VEC_NMI 8'h02
`define IRQPL_VEC_BASE 8'h0C
`define IRQPL_ACK_CYCLES 3'h3
`define IRQPL_SEL_HOLD 3'h4
`define IRQPL_CNT_ZERO 3'h0
`define IRQPL_CNT_ONE 3'h1
`define IRQPL_SRC_0 3'h0
`define IRQPL_SRC_1 3'h1
`define IRQPL_SRC_2 3'h2
`define IRQPL_SRC_3 3'h3
`define IRQPL_SRC_4 3'h4
`define IRQPL_NUM_SYNC 7
`define IRQPL_SYNC_NMI 5
`define IRQPL_SYNC_SEL 6

`endif

/* hdl/irqpl_pkg.sv */
// types of the interrupt request pin logic
package irqpl_pkg;

    typedef enum logic [1:0] {
        DEV_IDLE = 2'b01,
        DEV_FETCH = 2'b10
    } irqpl_dev_state_type;

    typedef enum logic [2:0] {
        HOST_IDLE = 3'b001,
        HOST_REQ = 3'b010,
        HOST_SEL = 3'b100
    } irqpl_host_state_type;

endpackage : irqpl_pkg

/* hdl/irqpl_if.sv */
// pin bundle between the interrupt unit and the external requesters
`timescale 1ns/1ps
interface irqpl_if;
    logic maskable_request_0;
    logic maskable_request_1;
    logic maskable_request_2;
    logic maskable_request_3;
    logic maskable_request_4;
    logic nmi;
    logic cascade_ack_out_0_n;
    logic cascade_ack_0_oe;
    logic pin3_out;
    logic pin3_oe;
    logic [7:0] type_bus;
    logic type_bus_oe;

    modport device (
        input maskable_request_0, maskable_request_1, maskable_request_2,
        input maskable_request_3, maskable_request_4, nmi, type_bus, type_bus_oe,
        output cascade_ack_out_0_n, cascade_ack_0_oe, pin3_out, pin3_oe
    );

    modport host (
        output maskable_request_0, maskable_request_1, maskable_request_2,
        output maskable_request_3, maskable_request_4, nmi, type_bus, type_bus_oe,
        input cascade_ack_out_0_n, cascade_ack_0_oe, pin3_out, pin3_oe
    );
endinterface : irqpl_if

/* hdl/irqpl_host.sv */
// external requester end: request pins, cascade peripherals, slave master
`timescale 1ns/1ps
`include "irqpl_defines.svh"
module irqpl_host #(
    parameter int NUM_REQ = `IRQPL_NUM_REQ,
    parameter int TYPE_W = `IRQPL_TYPE_W
) (
    input wire logic i_core_clk,
    input wire logic i_srst,
    irqpl_if.host pins,
    input wire logic [NUM_REQ-1:0] i_request,
    input wire logic i_nmi,
    input wire logic i_cascade_0,
    input wire logic i_cascade_1,
    input wire logic i_slave_mode,
    input wire logic [TYPE_W-1:0] i_type_0,
    input wire logic [TYPE_W-1:0] i_type_1,
    input wire logic [TYPE_W-1:0] i_slave_type,
    input wire logic i_slave_start,
    output logic o_slave_busy,
    output logic o_device_irq
);

    // ****************************************
    // pin drive and slave master sequence
    // ****************************************
    irqpl_pkg::irqpl_host_state_type state, next_state;
    logic [NUM_REQ-1:0] req, next_req;
    logic nmi, next_nmi;
    logic select, next_select;
    logic [2:0] count, next_count;
    logic [TYPE_W-1:0] bus, next_bus;
    logic bus_oe, next_bus_oe;
    logic ack_0, ack_1;

    assign ack_0 = i_cascade_0 && pins.cascade_ack_0_oe && !pins.cascade_ack_out_0_n;
    assign ack_1 = i_cascade_1 && !i_slave_mode && pins.pin3_oe && !pins.pin3_out;

    always_comb begin
        next_state = state;
        next_count = count;
        next_select = 1'b0;
        next_req = i_request;
        next_nmi = i_nmi;
        next_bus = bus;
        next_bus_oe = 1'b0;
        if (ack_0) begin
            next_bus = i_type_0;
            next_bus_oe = 1'b1;
        end else if (ack_1) begin
            next_bus = i_type_1;
            next_bus_oe = 1'b1;
        end
        if (i_slave_mode) begin
            next_req[0] = 1'b0;
            unique case (state)
                irqpl_pkg::HOST_IDLE: begin
                    if (i_slave_start) begin
                        next_state = irqpl_pkg::HOST_REQ;
                        next_count = `IRQPL_SEL_HOLD;
                        next_req[0] = 1'b1;
                    end
                end
                irqpl_pkg::HOST_REQ: begin
                    next_req[0] = 1'b1;
                    if (count == `IRQPL_CNT_ONE) begin
                        next_state = irqpl_pkg::HOST_SEL;
                        next_count = `IRQPL_SEL_HOLD;
                        next_select = 1'b1;
                        next_bus = i_slave_type;
                        next_bus_oe = 1'b1;
                    end else begin
                        next_count = count - `IRQPL_CNT_ONE;
                    end
                end
                irqpl_pkg::HOST_SEL: begin
                    next_req[0] = 1'b1;
                    next_bus = i_slave_type;
                    next_bus_oe = 1'b1;
                    if (count == `IRQPL_CNT_ONE) begin
                        next_state = irqpl_pkg::HOST_IDLE;
                        next_count = `IRQPL_CNT_ZERO;
                        next_req[0] = 1'b0;
                        next_bus_oe = 1'b0;
                    end else begin
                        next_select = 1'b1;
                        next_count = count - `IRQPL_CNT_ONE;
                    end
                end
            endcase
        end else begin
            next_state = irqpl_pkg::HOST_IDLE;
            next_count = `IRQPL_CNT_ZERO;
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (i_srst) begin
            state <= irqpl_pkg::HOST_IDLE;
            req <= '0;
            nmi <= 1'b0;
            select <= 1'b0;
            count <= `IRQPL_CNT_ZERO;
            bus <= '0;
            bus_oe <= 1'b0;
        end else begin
            state <= next_state;
            req <= next_req;
            nmi <= next_nmi;
            select <= next_select;
            count <= next_count;
            bus <= next_bus;
            bus_oe <= next_bus_oe;
        end
    end

    assign pins.maskable_request_0 = req[0];
    assign pins.maskable_request_1 = i_slave_mode ? ~select : req[1];
    assign pins.maskable_request_2 = req[2];
    assign pins.maskable_request_3 = req[3];
    assign pins.maskable_request_4 = req[4];
    assign pins.nmi = nmi;
    assign pins.type_bus = bus;
    assign pins.type_bus_oe = bus_oe;
    assign o_slave_busy = (state != irqpl_pkg::HOST_IDLE);
    assign o_device_irq = i_slave_mode && pins.pin3_oe && pins.pin3_out;

endmodule : irqpl_host

/* dv/irqpl_chk.sv */
// concurrent checks on the interrupt pin bundle
`timescale 1ns/1ps
module irqpl_chk (
    input wire logic i_core_clk,
    input wire logic i_srst,
    input wire logic maskable_request_0,
    input wire logic maskable_request_1,
    input wire logic cascade_ack_out_0_n,
    input wire logic cascade_ack_0_oe,
    input wire logic pin3_out,
    input wire logic pin3_oe,
    input wire logic [7:0] type_bus,
    input wire logic type_bus_oe
);
    // ****************************************
    // pin protocol checks
    // ****************************************
    default clocking cb @(posedge i_core_clk);
    endclocking
    default disable iff (i_srst);

    a_ack_idle_reset: assert property ($fell(i_srst) |-> cascade_ack_out_0_n)
        else $error("ack zero active after reset");
    a_ack0_cause: assert property ($fell(cascade_ack_out_0_n) |-> $past(maskable_request_0))
        else $error("ack zero without request zero");
    a_ack0_width: assert property ($fell(cascade_ack_out_0_n)
        |-> !cascade_ack_out_0_n [*3] ##1 cascade_ack_out_0_n)
        else $error("ack zero width wrong");
    a_ack1_width: assert property ($fell(pin3_out) && pin3_oe
        |-> $past(maskable_request_1) ##0 !pin3_out [*3] ##1 pin3_out)
        else $error("ack one width or cause wrong");
    a_one_fetch: assert property (!cascade_ack_out_0_n && cascade_ack_0_oe && pin3_oe
        |-> pin3_out)
        else $error("both acks active");
    a_type_on_ack: assert property ($fell(cascade_ack_out_0_n) || ($fell(pin3_out) && pin3_oe)
        |=> type_bus_oe)
        else $error("type not driven during ack");
    a_bus_owner: assert property ($rose(type_bus_oe)
        |-> !cascade_ack_out_0_n || !pin3_out || !maskable_request_1)
        else $error("type bus driven unasked");
    a_sel_after_req: assert property ($fell(maskable_request_1) && type_bus_oe
        |-> maskable_request_0 && $past(maskable_request_0, 3))
        else $error("select before request zero");
    a_sel_hold: assert property ($fell(maskable_request_1) && type_bus_oe
        |-> (!maskable_request_1 && type_bus_oe) [*4] ##1 maskable_request_1)
        else $error("select length wrong");
    a_type_steady: assert property ($fell(maskable_request_1) && type_bus_oe
        |=> $stable(type_bus) [*2])
        else $error("type moved under select");
endmodule : irqpl_chk

/* dv/irqpl_tb.sv */
// self-checking bench joining the device and host ends
`timescale 1ns/1ps
module irqpl_tb;
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic [4:0] mask = 5'h00;
    logic [4:0] lvl = 5'h0A;
    logic [4:0] req = 5'h00;
    logic casc0 = 1'b0;
    logic casc1 = 1'b0;
    logic slave = 1'b0;
    logic ireq = 1'b1;
    logic en_set = 1'b0;
    logic bnd = 1'b0;
    logic nmi = 1'b0;
    logic [7:0] type0 = 8'hA5;
    logic [7:0] type1 = 8'h5A;
    logic [7:0] stype = 8'h3C;
    logic sstart = 1'b0;
    logic cpu_req, vvalid, vnmi, gen, sbusy, dirq;
    logic [7:0] vec;
    int err_total = 0;
    int cmp_count = 0;
    int cycles = 0;

    always #12.5 clk = ~clk;

    irqpl_if u_irqpl_if ();
    irqpl_device u_irqpl_device (
        .i_core_clk(clk), .i_srst(srst), .pins(u_irqpl_if), .i_mask(mask),
        .i_trigger_level(lvl), .i_cascade_0(casc0), .i_cascade_1(casc1), .i_slave_mode(slave),
        .i_internal_req(ireq), .i_enable_set(en_set), .i_boundary(bnd), .o_cpu_request(cpu_req),
        .o_vector_valid(vvalid), .o_vector(vec), .o_vector_is_nmi(vnmi), .o_global_enable(gen)
    );
    irqpl_host u_irqpl_host (
        .i_core_clk(clk), .i_srst(srst), .pins(u_irqpl_if), .i_request(req), .i_nmi(nmi),
        .i_cascade_0(casc0), .i_cascade_1(casc1), .i_slave_mode(slave), .i_type_0(type0),
        .i_type_1(type1), .i_slave_type(stype), .i_slave_start(sstart), .o_slave_busy(sbusy),
        .o_device_irq(dirq)
    );
    irqpl_chk u_irqpl_chk (
        .i_core_clk(clk), .i_srst(srst),
        .maskable_request_0(u_irqpl_if.maskable_request_0),
        .maskable_request_1(u_irqpl_if.maskable_request_1),
        .cascade_ack_out_0_n(u_irqpl_if.cascade_ack_out_0_n),
        .cascade_ack_0_oe(u_irqpl_if.cascade_ack_0_oe),
        .pin3_out(u_irqpl_if.pin3_out), .pin3_oe(u_irqpl_if.pin3_oe),
        .type_bus(u_irqpl_if.type_bus), .type_bus_oe(u_irqpl_if.type_bus_oe)
    );

    // ****************************************
    // access tasks
    // ****************************************
    task automatic check(input logic [7:0] got, input logic [7:0] exp, input string msg);
        cmp_count++;
        if (got !== exp) begin
            err_total++;
            $display("BAD %0t %s got %h exp %h", $time, msg, got, exp);
        end
    endtask : check

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask : tick

    task automatic enable;
        @(posedge clk) en_set <= 1'b1;
        @(posedge clk) en_set <= 1'b0;
    endtask : enable

    task automatic nmi_pulse;
        @(posedge clk) nmi <= 1'b1;
        tick(2);
        nmi <= 1'b0;
        tick(5);
    endtask : nmi_pulse

    task automatic take(input logic [7:0] ev, input logic en);
        int n;
        n = 0;
        while (cpu_req !== 1'b1 && n < 40) begin
            @(negedge clk);
            n++;
        end
        check({7'h00, cpu_req}, 8'h01, "no request to cpu");
        @(posedge clk) bnd <= 1'b1;
        @(posedge clk) bnd <= 1'b0;
        n = 0;
        do begin
            @(negedge clk);
            n++;
        end while (vvalid !== 1'b1 && n < 10);
        check({7'h00, vvalid}, 8'h01, "no vector");
        check(vec, ev, "vector");
        check({7'h00, vnmi}, {7'h00, en}, "nmi flag");
        check({7'h00, gen}, 8'h00, "enable not cleared");
    endtask : take

    task automatic done(input string s);
        $display("test %s done", s);
    endtask : done

    task automatic report_and_stop;
        $display("compares %0d mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : report_and_stop

    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            err_total++;
            report_and_stop;
        end
    end

    // ****************************************
    // test sequence
    // ****************************************
    initial begin
        tick(4);
        srst <= 1'b0;
        @(negedge clk);
        check({6'h00, gen, cpu_req}, 8'h00, "reset outputs");
        check({7'h00, u_irqpl_if.cascade_ack_out_0_n}, 8'h01, "ack at reset");
        done("reset");
        for (int i = 0; i < 5; i++) begin
            enable;
            req[i] <= 1'b1;
            take(8'h0C + 8'(i), 1'b0);
            @(posedge clk) req <= 5'h00;
            tick(4);
        end
        done("sources");
        req <= 5'h18;
        tick(3);
        req <= 5'h00;
        tick(6);
        enable;
        take(8'h10, 1'b0);
        enable;
        @(negedge clk);
        check({7'h00, cpu_req}, 8'h00, "level pulse kept");
        @(posedge clk) mask <= 5'h04;
        lvl <= 5'h0E;
        req <= 5'h04;
        tick(8);
        @(negedge clk);
        check({7'h00, cpu_req}, 8'h00, "masked source taken");
        @(posedge clk) mask <= 5'h00;
        take(8'h0E, 1'b0);
        @(posedge clk) req <= 5'h0A;
        tick(6);
        enable;
        take(8'h0D, 1'b0);
        tick(6);
        @(negedge clk);
        check({7'h00, cpu_req}, 8'h00, "taken while disabled");
        @(posedge clk) req <= 5'h08;
        tick(4);
        enable;
        take(8'h0F, 1'b0);
        @(posedge clk) req <= 5'h00;
        done("mask and priority");
        mask <= 5'h1F;
        nmi_pulse;
        take(8'h02, 1'b1);
        nmi_pulse;
        take(8'h02, 1'b1);
        @(posedge clk) mask <= 5'h00;
        lvl <= 5'h0F;
        req <= 5'h01;
        nmi_pulse;
        enable;
        take(8'h02, 1'b1);
        enable;
        take(8'h0C, 1'b0);
        @(posedge clk) req <= 5'h00;
        tick(5);
        lvl <= 5'h00;
        tick(4);
        done("nmi");
        for (int k = 0; k < 2; k++) begin
            @(posedge clk) casc0 <= (k == 0);
            casc1 <= (k == 1);
            tick(3);
            @(negedge clk);
            check({7'h00, (k == 1) ? u_irqpl_if.pin3_oe : u_irqpl_if.cascade_ack_0_oe}, 8'h01,
                "pin not acknowledge");
            @(posedge clk) req <= (k == 1) ? 5'h08 : 5'h04;
            enable;
            tick(8);
            @(negedge clk);
            check({7'h00, cpu_req}, 8'h00, "reassigned pin taken");
            @(posedge clk) req <= (k == 1) ? 5'h02 : 5'h01;
            take((k == 1) ? type1 : type0, 1'b0);
            @(posedge clk) req <= 5'h00;
            tick(4);
        end
        done("cascade");
        @(posedge clk) casc1 <= 1'b0;
        tick(2);
        slave <= 1'b1;
        tick(3);
        @(negedge clk);
        check({6'h00, dirq, u_irqpl_if.pin3_out}, 8'h03, "irq not forwarded");
        enable;
        @(posedge clk) sstart <= 1'b1;
        @(posedge clk) sstart <= 1'b0;
        take(stype, 1'b0);
        for (int n = 0; n < 20 && sbusy !== 1'b0; n++) begin
            @(negedge clk);
        end
        check({7'h00, sbusy}, 8'h00, "slave sequence stuck");
        done("slave");
        report_and_stop;
    end
endmodule : irqpl_tb
